// ---- drb_pkg.sv ----
// Shared constants, types and helpers of the DDR3 burst datapath
package drb_pkg;

	// ==========================================================
	// Widths and depths
	localparam int DQ_W = 8;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 14;
	localparam int COL_W = 10;
	localparam int BURST_W = 3;
	localparam int MEM_COL_W = 6;
	localparam int MEM_AW = BANK_W + MEM_COL_W;
	localparam int MEM_DEPTH = 512;
	localparam int PIPE_DEPTH = 32;
	localparam int LAT_W = 5;
	localparam int SYNC_W = 33;

	// ==========================================================
	// Field positions on the address pins
	localparam int A10_BIT = 10;
	localparam int A12_BIT = 12;

	// ==========================================================
	// Burst field codes and counts
	localparam logic [1:0] MODE_BL8 = 2'h0;
	localparam logic [1:0] MODE_OTF = 2'h1;
	localparam logic [1:0] MODE_BC4 = 2'h2;
	localparam logic [3:0] BL8_LEN = 4'h8;
	localparam logic [3:0] BC4_LEN = 4'h4;
	localparam logic [2:0] BL8_LAST = 3'h7;
	localparam logic [2:0] BC4_LAST = 3'h3;
	localparam logic [LAT_W-1:0] LAT_ONE = 5'h01;
	localparam logic [LAT_W-1:0] LAT_TWO = 5'h02;

	// ==========================================================
	// Types
	typedef struct packed {
		logic valid;
		logic wr;
		logic bc4;
		logic ap;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0] col;
	} drb_cmd_type;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h0,
		RD_PRE = 2'h1,
		RD_BURST = 2'h2
	} drb_rd_state_type;

	// ==========================================================
	// Reset values
	localparam drb_cmd_type CMD_IDLE = '0;

	// ==========================================================
	// Helpers
	function automatic logic is_bc4(input logic [1:0] mode, input logic a12);
		return (mode == MODE_BC4) || ((mode == MODE_OTF) && !a12);
	endfunction : is_bc4

	function automatic logic [2:0] last_idx(input logic bc4);
		return bc4 ? BC4_LAST : BL8_LAST;
	endfunction : last_idx

	function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] idx,
		input logic ilv, input logic bc4);
		logic [2:0] s;
		s = ilv ? (start ^ idx) : (start + idx);
		if (bc4) begin
			s[2] = start[2];
		end
		return s;
	endfunction : burst_col

	function automatic logic [MEM_AW-1:0] mem_addr(input drb_cmd_type c, input logic [2:0] idx,
		input logic ilv);
		return {c.bank, c.col[MEM_COL_W-1:BURST_W], burst_col(c.col[BURST_W-1:0], idx, ilv, c.bc4)};
	endfunction : mem_addr

endpackage : drb_pkg

// ---- drb_mem_if.sv ----
// Port bundle between the datapath and its data store
`timescale 1ns/100ps
interface drb_mem_if;
	import drb_pkg::*;
	logic we;
	logic [MEM_AW-1:0] waddr;
	logic [DQ_W-1:0] wdata;
	logic [MEM_AW-1:0] raddr;
	logic [DQ_W-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : drb_mem_if

// ---- drb_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module drb_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] stage1;

	// ==========================================================
	// Stages
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			stage1 <= '0;
			q_o <= '0;
		end else if (ce_i) begin
			stage1 <= d_i;
			q_o <= stage1;
		end
	end
endmodule : drb_sync

// ---- drb_mem.sv ----
// Data store with registered read
`timescale 1ns/100ps
module drb_mem
	import drb_pkg::*;
(
	// Clock
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Store port
	drb_mem_if.store bus
);
	logic [DQ_W-1:0] arr [0:MEM_DEPTH-1];

	// ==========================================================
	// Write and read
	always_ff @(posedge ref_clk_i) begin
		if (ce_i && bus.we) begin
			arr[bus.waddr] <= bus.wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bus.rdata <= '0;
		end else if (ce_i) begin
			bus.rdata <= arr[bus.raddr];
		end
	end
endmodule : drb_mem

// ---- drb_burst.sv ----
// DDR3 read and write burst datapath, device side
`timescale 1ns/100ps
// Behaviour
// - Burst field 00, or 01 with A12 high, gives an eight-element burst
// - Burst field 10, or 01 with A12 low, gives a four-element chop
// - Eight-element read sends the addressed element then seven more in burst order
// - Strobe held low, complement high, for the preamble; before the preamble strobes float
// - Strobe stays low for one half clock after the last transition
// - Before the preamble data lines float or terminate per the termination input
// - After the postamble data lines release or terminate per the termination input
// - Write carries bank, column and auto-precharge; auto-precharge closes row at end
// - A write burst always runs to its full length
// - First write element taken at strobe rise write latency after command, then each edge
// - Mask high at an element discards it; low writes it
// - With no burst pending the data lines float and extra input is ignored
// - Chained writes tCCD apart carry data straight after the previous burst
// - First read element appears additive plus CAS latency clocks after the read
// - Reads are never truncated; chained chop reads leave a data gap
module drb_burst
	import drb_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration
	input wire logic [1:0] burst_mode_i,
	input wire logic burst_order_i,
	input wire logic [3:0] add_lat_i,
	input wire logic [3:0] cas_lat_i,
	input wire logic [3:0] cas_wr_lat_i,
	// Link inputs
	input wire logic ck_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [BANK_W-1:0] ba_i,
	input wire logic [ADDR_W-1:0] a_i,
	input wire logic odt_i,
	input wire logic dm_i,
	input wire logic [DQ_W-1:0] dq_i,
	input wire logic dqs_i,
	// Link drives
	output logic [DQ_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic dq_term_o,
	output logic dqs_o,
	output logic dqs_n_o,
	output logic dqs_oe_o,
	// Status
	output logic row_close_o,
	output logic [BANK_W-1:0] row_close_bank_o,
	output logic rd_busy_o,
	output logic wr_busy_o
);
	// ==========================================================
	// Pin synchronisation and edges
	logic [SYNC_W-1:0] sync_q;
	logic ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, dm_s, dqs_s;
	logic [BANK_W-1:0] ba_s;
	logic [ADDR_W-1:0] a_s;
	logic [DQ_W-1:0] dq_s;
	logic ck_q, dqs_q;
	logic ck_rise, ck_fall, ck_edge, dqs_edge;

	drb_sync #(.WIDTH(SYNC_W)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, a_i, odt_i, dm_i, dq_i, dqs_i}),
		.q_o(sync_q)
	);

	assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s, odt_s, dm_s, dq_s, dqs_s} = sync_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ck_q <= 1'h0;
			dqs_q <= 1'h0;
		end else if (ce_i) begin
			ck_q <= ck_s;
			dqs_q <= dqs_s;
		end
	end

	assign ck_rise = ck_s & ~ck_q;
	assign ck_fall = ~ck_s & ck_q;
	assign ck_edge = ck_rise | ck_fall;
	assign dqs_edge = dqs_s ^ dqs_q;

	// ==========================================================
	// Command decode and latency pipeline
	logic cmd_hit;
	drb_cmd_type new_cmd;
	drb_cmd_type pipe [0:PIPE_DEPTH-1];
	logic [LAT_W-1:0] rd_lat, wr_lat;
	drb_cmd_type rd_due, rd_soon, wr_soon;
	logic rd_start, rd_pre_req;

	assign cmd_hit = ck_rise & ~cs_n_s & ras_n_s & ~cas_n_s;

	always_comb begin
		new_cmd.valid = cmd_hit;
		new_cmd.wr = ~we_n_s;
		new_cmd.bc4 = is_bc4(burst_mode_i, a_s[A12_BIT]);
		new_cmd.ap = a_s[A10_BIT];
		new_cmd.bank = ba_s;
		new_cmd.col = a_s[COL_W-1:0];
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < PIPE_DEPTH; i++) begin
				pipe[i] <= CMD_IDLE;
			end
		end else if (ce_i && ck_rise) begin
			pipe[0] <= new_cmd;
			for (int i = 1; i < PIPE_DEPTH; i++) begin
				pipe[i] <= pipe[i-1];
			end
		end
	end

	assign rd_lat = {1'h0, add_lat_i} + {1'h0, cas_lat_i};
	assign wr_lat = {1'h0, add_lat_i} + {1'h0, cas_wr_lat_i};
	assign rd_due = pipe[rd_lat - LAT_ONE];
	assign rd_soon = pipe[rd_lat - LAT_TWO];
	assign wr_soon = pipe[wr_lat - LAT_TWO];
	assign rd_start = ck_rise & rd_due.valid & ~rd_due.wr;
	assign rd_pre_req = ck_rise & rd_soon.valid & ~rd_soon.wr;

	// ==========================================================
	// Read sequencer
	drb_mem_if mb ();
	drb_rd_state_type rd_state;
	drb_cmd_type rd_cmd;
	logic [2:0] rd_idx;
	logic [MEM_AW-1:0] rd_addr;
	logic rd_load, rd_load_q, rd_drive, rd_last, rd_end;

	assign rd_last = rd_idx == last_idx(rd_cmd.bc4);
	assign rd_end = ck_rise & (rd_state == RD_BURST) & rd_last;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rd_state <= RD_IDLE;
			rd_cmd <= CMD_IDLE;
			rd_idx <= 3'h0;
			rd_addr <= '0;
			rd_load <= 1'h0;
			rd_drive <= 1'h0;
			dqs_o <= 1'h0;
			dqs_n_o <= 1'h1;
			dqs_oe_o <= 1'h0;
		end else if (ce_i) begin
			rd_load <= 1'h0;
			if (rd_start) begin
				rd_state <= RD_BURST;
				rd_cmd <= rd_due;
				rd_idx <= 3'h0;
				rd_addr <= mem_addr(rd_due, 3'h0, burst_order_i);
				rd_load <= 1'h1;
				rd_drive <= 1'h1;
				dqs_o <= 1'h1;
				dqs_n_o <= 1'h0;
				dqs_oe_o <= 1'h1;
			end else begin
				unique case (rd_state)
					RD_IDLE: begin
						if (rd_pre_req) begin
							rd_state <= RD_PRE;
							dqs_o <= 1'h0;
							dqs_n_o <= 1'h1;
							dqs_oe_o <= 1'h1;
						end
					end
					RD_PRE: begin
						if (ck_rise) begin
							rd_state <= RD_IDLE;
							dqs_oe_o <= 1'h0;
						end
					end
					RD_BURST: begin
						if (ck_edge && !rd_last) begin
							rd_idx <= rd_idx + 3'h1;
							rd_addr <= mem_addr(rd_cmd, rd_idx + 3'h1, burst_order_i);
							rd_load <= 1'h1;
							dqs_o <= ck_rise;
							dqs_n_o <= ~ck_rise;
						end else if (rd_pre_req) begin
							rd_state <= RD_PRE;
							rd_drive <= 1'h0;
							dqs_o <= 1'h0;
							dqs_n_o <= 1'h1;
						end else if (ck_rise) begin
							rd_state <= RD_IDLE;
							rd_drive <= 1'h0;
							dqs_oe_o <= 1'h0;
						end
					end
					default: begin
						rd_state <= RD_IDLE;
					end
				endcase
			end
		end
	end

	assign mb.raddr = rd_addr;

	// Output data one cycle behind the store read
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rd_load_q <= 1'h0;
			dq_o <= '0;
			dq_oe_o <= 1'h0;
			dq_term_o <= 1'h0;
		end else if (ce_i) begin
			rd_load_q <= rd_load;
			if (rd_load_q) begin
				dq_o <= mb.rdata;
			end
			dq_oe_o <= rd_drive;
			dq_term_o <= odt_s & ~rd_drive;
		end
	end

	// ==========================================================
	// Write sequencer
	drb_cmd_type wr_pend_cmd, wr_cmd;
	logic wr_pend, wr_act, slot_valid, wr_last, wr_end;
	logic [2:0] wr_idx;
	logic [MEM_AW-1:0] slot_addr;

	assign wr_last = wr_idx == last_idx(wr_cmd.bc4);
	assign wr_end = ck_edge & wr_act & wr_last;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_pend <= 1'h0;
			wr_pend_cmd <= CMD_IDLE;
			wr_act <= 1'h0;
			wr_cmd <= CMD_IDLE;
			wr_idx <= 3'h0;
			slot_valid <= 1'h0;
			slot_addr <= '0;
		end else if (ce_i) begin
			if (ck_rise && wr_soon.valid && wr_soon.wr) begin
				wr_pend <= 1'h1;
				wr_pend_cmd <= wr_soon;
			end else if (ck_fall && wr_pend) begin
				wr_pend <= 1'h0;
			end
			if (ck_fall && wr_pend) begin
				wr_act <= 1'h1;
				wr_cmd <= wr_pend_cmd;
				wr_idx <= 3'h0;
				slot_valid <= 1'h1;
				slot_addr <= mem_addr(wr_pend_cmd, 3'h0, burst_order_i);
			end else if (ck_edge && wr_act && !wr_last) begin
				wr_idx <= wr_idx + 3'h1;
				slot_valid <= 1'h1;
				slot_addr <= mem_addr(wr_cmd, wr_idx + 3'h1, burst_order_i);
			end else if (wr_end) begin
				wr_act <= 1'h0;
				slot_valid <= 1'h0;
			end else if (dqs_edge && slot_valid) begin
				slot_valid <= 1'h0;
			end
		end
	end

	assign mb.we = ce_i & dqs_edge & slot_valid & ~dm_s;
	assign mb.waddr = slot_addr;
	assign mb.wdata = dq_s;

	drb_mem u_mem (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.bus(mb)
	);

	// ==========================================================
	// Row close and status
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			row_close_o <= 1'h0;
			row_close_bank_o <= '0;
			rd_busy_o <= 1'h0;
			wr_busy_o <= 1'h0;
		end else if (ce_i) begin
			row_close_o <= 1'h0;
			if (rd_end && rd_cmd.ap) begin
				row_close_o <= 1'h1;
				row_close_bank_o <= rd_cmd.bank;
			end else if (wr_end && wr_cmd.ap) begin
				row_close_o <= 1'h1;
				row_close_bank_o <= wr_cmd.bank;
			end
			rd_busy_o <= rd_state != RD_IDLE;
			wr_busy_o <= wr_act | wr_pend;
		end
	end

	// ==========================================================
	// Checks
	logic [3:0] rd_elems;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rd_elems <= 4'h0;
		end else if (ce_i) begin
			rd_elems <= rd_start ? 4'h0 : rd_elems + {3'h0, rd_load};
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_preamble;
		dqs_oe_o && !dqs_o && dqs_n_o && !rd_drive;
	endsequence

	sequence s_postamble;
		!dqs_o ##1 !dqs_oe_o;
	endsequence

	a_burst_len_sel: assert property (cmd_hit && ce_i |=>
		pipe[0].bc4 == is_bc4($past(burst_mode_i), $past(a_s[A12_BIT])))
		else $error("burst length selection wrong");
	a_rd_latency: assert property (rd_start && ce_i |=>
		rd_state == RD_BURST && rd_idx == 3'h0 && dqs_o && dqs_oe_o)
		else $error("read burst did not start at read latency");
	a_rd_preamble: assert property (rd_pre_req && ce_i && rd_state == RD_IDLE |=> s_preamble)
		else $error("read preamble missing");
	a_rd_count: assert property (rd_end |->
		rd_elems == (rd_cmd.bc4 ? BC4_LEN : BL8_LEN))
		else $error("read burst element count wrong");
	a_rd_postamble: assert property (rd_end && ce_i && !rd_start && !rd_pre_req |-> s_postamble)
		else $error("read postamble wrong");
	a_dq_release: assert property (!rd_drive && ce_i |=>
		!dq_oe_o && dq_term_o == $past(odt_s))
		else $error("data lines not released or terminated");
	a_wr_ignore: assert property (!wr_act && !wr_pend |-> !mb.we)
		else $error("write outside a burst");
	a_wr_mask: assert property (mb.we |-> !dm_s && wr_act && slot_valid)
		else $error("masked element written");
	a_wr_first: assert property (ck_fall && wr_pend && ce_i |=>
		wr_act && wr_idx == 3'h0 && slot_valid && !wr_pend)
		else $error("write burst did not open");
	a_wr_full: assert property (ck_edge && wr_act && !wr_last && ce_i |=> wr_act)
		else $error("write burst truncated");
	a_row_close: assert property (rd_end && rd_cmd.ap && ce_i |=>
		row_close_o && row_close_bank_o == $past(rd_cmd.bank))
		else $error("auto precharge close missing");
endmodule : drb_burst

// ---- drb_ctl_model.sv ----
// Controller model: link clock, commands, write strobe and data
`timescale 1ns/100ps
module drb_ctl_model
	import drb_pkg::*;
(
	// Link clock and command
	output logic ck_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [BANK_W-1:0] ba_o,
	output logic [ADDR_W-1:0] a_o,
	// Write data
	output logic dm_o,
	output logic [DQ_W-1:0] dq_o,
	output logic dqs_o
);
	logic [8:0] wq[$];
	time t_cmd;
	initial begin
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		ba_o = '0;
		a_o = '0;
		{dm_o, dq_o} = 9'h000;
		dqs_o = 1'h1;
		ck_o = 1'h0;
		#3;
		forever #40 ck_o = ~ck_o;
	end
	// ==========================================================
	// Command held a half clock either side of the CK rise
	task automatic cmd(input logic wr, input logic [BANK_W-1:0] bk, input logic [9:0] col,
		input logic ap, input logic a12);
		@(negedge ck_o);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = {3'h2, ~wr};
		ba_o = bk;
		a_o = {1'h0, a12, 1'h0, ap, col};
		@(posedge ck_o);
		t_cmd = $time;
		@(negedge ck_o);
		cs_n_o = 1'h1;
	endtask : cmd
	// ==========================================================
	// Whole burst, never cut short; one stray closing edge always, four more on request
	task automatic wburst(input int wl, input int n, input logic extra);
		repeat (wl - 1) @(posedge ck_o);
		dqs_o = 1'h1;
		@(negedge ck_o);
		dqs_o = 1'h0;
		for (int k = 0; k < n; k++) begin
			#20;
			{dm_o, dq_o} = wq.pop_front();
			@(ck_o);
			dqs_o = ~dqs_o;
		end
		#20;
		dq_o = ~dq_o;
		@(ck_o);
		dqs_o = 1'h1;
		for (int k = 0; k < (extra ? 4 : 0); k++) begin
			#20;
			{dm_o, dq_o} = 9'h0A5;
			@(ck_o);
			dqs_o = ~dqs_o;
		end
	endtask : wburst
endmodule : drb_ctl_model

// ---- drb_burst_tb.sv ----
// Self-checking bench of the burst datapath
`timescale 1ns/100ps
module drb_burst_tb;
	import drb_pkg::*;
	logic ref_clk_i;
	logic rst_i = 1'h1;
	logic [1:0] burst_mode = 2'h0;
	logic ord = 1'h0;
	logic [3:0] al = 4'h0;
	logic [3:0] cl = 4'h5;
	logic [3:0] cwl = 4'h5;
	logic odt = 1'h0;
	logic ck, cs_n, ras_n, cas_n, we_n, dm, dqs_w;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] a;
	logic [DQ_W-1:0] dq_w, dq_o;
	logic dq_oe_o, dq_term_o, dqs_o, dqs_n_o, dqs_oe_o, row_close_o, rd_busy_o, wr_busy_o;
	logic [BANK_W-1:0] row_close_bank_o;
	logic [2:0] cl_bank = 3'h0;
	logic [7:0] mem_exp [512];
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int closes = 0;
	// ==========================================================
	// Clock, partner, design
	initial begin
		ref_clk_i = 1'h0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	drb_ctl_model ctl (.ck_o(ck), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
		.we_n_o(we_n), .ba_o(ba), .a_o(a), .dm_o(dm), .dq_o(dq_w), .dqs_o(dqs_w));
	drb_burst uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'h1), .burst_mode_i(burst_mode),
		.burst_order_i(ord), .add_lat_i(al), .cas_lat_i(cl), .cas_wr_lat_i(cwl), .ck_i(ck),
		.cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .a_i(a),
		.odt_i(odt), .dm_i(dm), .dq_i(dq_w), .dqs_i(dqs_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.dq_term_o(dq_term_o), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o), .dqs_oe_o(dqs_oe_o),
		.row_close_o(row_close_o), .row_close_bank_o(row_close_bank_o),
		.rd_busy_o(rd_busy_o), .wr_busy_o(wr_busy_o));
	// ==========================================================
	// Watchdog and row-close monitor
	always @(negedge ref_clk_i) begin
		cyc++;
		if (row_close_o === 1'h1) begin
			closes++;
			cl_bank = row_close_bank_o;
		end
		if (cyc == 30000) begin
			errors++;
			end_of_test();
		end
	end
	// ==========================================================
	// Helpers
	task automatic end_of_test();
		$display("Checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	function automatic int blen(input logic a12);
		return (burst_mode == 2'h2 || (burst_mode == 2'h1 && !a12)) ? 4 : 8;
	endfunction : blen
	function automatic logic [2:0] bcol(input logic [2:0] st, input int i, input logic bc4);
		logic [2:0] x;
		x = ord ? (st ^ 3'(i)) : (st + 3'(i));
		if (bc4) begin
			x[2] = st[2];
		end
		return x;
	endfunction : bcol
	task automatic cfg(input logic [1:0] m, input logic o, input logic [3:0] ad,
		input logic [3:0] c, input logic [3:0] w, input logic t);
		@(posedge ref_clk_i);
		burst_mode <= m;
		ord <= o;
		al <= ad;
		cl <= c;
		cwl <= w;
		odt <= t;
		repeat (8) @(negedge ref_clk_i);
	endtask : cfg
	task automatic load(input logic [2:0] bk, input logic [9:0] col, input int n,
		input logic [7:0] mask, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			ctl.wq.push_back({mask[i], base + 8'(i)});
			if (!mask[i]) begin
				mem_exp[{bk, col[5:3], bcol(col[2:0], i, n == 4)}] = base + 8'(i);
			end
		end
	endtask : load
	task automatic wr(input logic [2:0] bk, input logic [9:0] col, input logic ap,
		input logic a12, input logic [7:0] mask, input logic [7:0] base, input logic extra);
		load(bk, col, blen(a12), mask, base);
		ctl.cmd(1'h1, bk, col, ap, a12);
		fork
			ctl.wburst(al + cwl, blen(a12), extra);
			begin
				repeat (int'(al) + int'(cwl)) @(posedge ck);
				@(negedge ref_clk_i);
				chk("wr_busy", 8'h1, {7'h0, wr_busy_o});
			end
		join
		chk("wr_hiz", 8'h0, {6'h0, dq_oe_o, wr_busy_o});
		repeat (12) @(negedge ref_clk_i);
	endtask : wr
	task automatic rd(input logic [2:0] bk, input logic [9:0] col, input logic ap,
		input logic a12);
		int w;
		int n;
		time d;
		logic p;
		n = blen(a12);
		ctl.cmd(1'h0, bk, col, ap, a12);
		w = 0;
		while (dqs_oe_o !== 1'h1 && w < 400) begin
			chk("term_idle", {7'h0, odt}, {7'h0, dq_term_o});
			@(negedge ref_clk_i);
			w++;
		end
		d = $time - ctl.t_cmd;
		chk("rd_lat", 8'h1, {7'h0, d > (al + cl - 1) * 80 && d < (al + cl) * 80});
		chk("pre_level", 8'h1, {6'h0, dqs_o, dqs_n_o});
		for (int i = 0; i < n; i++) begin
			p = dqs_o;
			w = 0;
			while (dqs_o === p && w < 12) begin
				@(negedge ref_clk_i);
				w++;
			end
			if (i == 0) begin
				chk("pre_len", 8'h8, 8'(w));
				chk("rd_busy", 8'h1, {7'h0, rd_busy_o});
			end
			repeat (3) @(negedge ref_clk_i);
			chk("rd_data", mem_exp[{bk, col[5:3], bcol(col[2:0], i, n == 4)}], dq_o);
		end
		chk("post_low", 8'h5, {5'h0, dqs_oe_o, dqs_o, dqs_n_o});
		@(negedge ref_clk_i);
		chk("post_end", 8'h0, {7'h0, dqs_oe_o});
		repeat (3) @(negedge ref_clk_i);
		chk("dq_after", {7'h0, odt}, {5'h0, rd_busy_o, dq_oe_o, dq_term_o});
	endtask : rd
	// ==========================================================
	// Scenarios
	task automatic s_basic();
		cfg(2'h0, 1'h0, 4'h0, 4'h5, 4'h5, 1'h0);
		wr(3'h1, 10'h013, 1'h0, 1'h0, 8'h00, 8'h10, 1'h1);
		rd(3'h1, 10'h013, 1'h0, 1'h0);
		chk("no_close", 8'h0, 8'(closes));
	endtask : s_basic
	task automatic s_chain();
		cfg(2'h3, 1'h1, 4'h1, 4'h5, 4'h4, 1'h0);
		load(3'h2, 10'h00D, 8, 8'h00, 8'h30);
		load(3'h2, 10'h012, 8, 8'h00, 8'h50);
		ctl.cmd(1'h1, 3'h2, 10'h00D, 1'h0, 1'h1);
		fork
			begin
				repeat (2) @(negedge ctl.ck_o);
				ctl.cmd(1'h1, 3'h2, 10'h012, 1'h0, 1'h1);
			end
			ctl.wburst(5, 16, 1'h0);
		join
		repeat (12) @(negedge ref_clk_i);
		rd(3'h2, 10'h00D, 1'h0, 1'h1);
		rd(3'h2, 10'h012, 1'h0, 1'h1);
	endtask : s_chain
	task automatic s_otf();
		cfg(2'h1, 1'h0, 4'h0, 4'h6, 4'h5, 1'h0);
		wr(3'h1, 10'h013, 1'h0, 1'h0, 8'h05, 8'hC0, 1'h0);
		rd(3'h1, 10'h013, 1'h0, 1'h1);
		rd(3'h1, 10'h016, 1'h0, 1'h0);
	endtask : s_otf
	task automatic s_ap_odt();
		cfg(2'h2, 1'h1, 4'h0, 4'h5, 4'h5, 1'h1);
		wr(3'h6, 10'h025, 1'h1, 1'h1, 8'h00, 8'h60, 1'h0);
		chk("close_wr", 8'h1, 8'(closes));
		chk("close_bank", 8'h6, {5'h0, cl_bank});
		rd(3'h6, 10'h025, 1'h1, 1'h1);
		chk("close_rd", 8'h2, 8'(closes));
	endtask : s_ap_odt
	// ==========================================================
	// Main sequence
	initial begin
		repeat (15) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("rst_out", 8'h1, {5'h0, dqs_oe_o, dq_oe_o, dqs_n_o});
		@(posedge ref_clk_i);
		rst_i <= 1'h0;
		repeat (8) @(negedge ref_clk_i);
		s_basic();
		s_chain();
		s_otf();
		s_ap_odt();
		end_of_test();
	end
endmodule : drb_burst_tb
